//--- hdl/iop_bus_regs.svh
// named codes and counts for the io processor bus interface
`ifndef IOP_BUS_REGS_SVH
`define IOP_BUS_REGS_SVH
// cycle type codes as pin levels on the active-low status lines
`define IOP_CODE_IO_FETCH  3'h0
`define IOP_CODE_IO_READ   3'h1
`define IOP_CODE_IO_WRITE  3'h2
`define IOP_CODE_UNUSED    3'h3
`define IOP_CODE_MEM_FETCH 3'h4
`define IOP_CODE_MEM_READ  3'h5
`define IOP_CODE_MEM_WRITE 3'h6
`define IOP_CODE_PASSIVE   3'h7
// upper address nibble forced on io space cycles (64k io space)
`define IOP_IO_ADDR_HI     4'h0
// idle states held after a throttled task program cycle
`define IOP_BLL_GAP        4'h7
`define IOP_GAP_ZERO       4'h0
`define IOP_GAP_STEP       4'h1
// next byte address for the second half of a split word
`define IOP_ADDR_STEP      20'h00001
`define IOP_BYTE_ZERO      8'h00
`define IOP_WORD_ZERO      16'h0000
`define IOP_ADDR_ZERO      20'h00000
// output enable levels, low while driving
`define IOP_DRIVE_N        1'b0
`define IOP_FLOAT_N        1'b1
`endif

//--- hdl/iop_bus_pkg.sv
// types shared by the io processor bus interface modules
package iop_bus_pkg;
	// bus cycle sequencer states
	typedef enum logic [2:0] {
		IOP_IDLE,
		IOP_T1,
		IOP_T2,
		IOP_T3,
		IOP_TW,
		IOP_T4
	} iop_bus_state_e;

	// request/grant exchange states
	typedef enum logic [2:0] {
		IOP_RG_IDLE,
		IOP_RG_REQ,
		IOP_RG_GAP,
		IOP_RG_WAIT,
		IOP_RG_OWN,
		IOP_RG_REL
	} iop_rg_state_e;
endpackage

//--- hdl/iop_lane_steer.sv
// byte lane steering for 8-bit and 16-bit physical buses
`timescale 1ns/100ps
`include "iop_bus_regs.svh"
module iop_lane_steer (
	// cycle shape
	input  wire logic        phys16_i,
	input  wire logic        word_i,
	input  wire logic        a0_i,
	// data
	input  wire logic [7:0]  wbyte_i,
	input  wire logic [15:0] wword_i,
	input  wire logic [15:0] ad_i,
	// steering results
	output logic      [15:0] lanes_o,
	output logic             lo_data_o,
	output logic             hi_data_o,
	output logic             bhe_n_o,
	output logic      [7:0]  rbyte_o
);
	// lane choice; word is only ever set for an even address on the wide bus
	always_comb begin
		lanes_o   = {`IOP_BYTE_ZERO, wbyte_i};
		lo_data_o = 1'b1;
		hi_data_o = 1'b0;
		bhe_n_o   = 1'b1;
		rbyte_o   = ad_i[7:0];
		if (!phys16_i) begin
			bhe_n_o = 1'b1;
		end else if (word_i) begin
			lanes_o   = wword_i;
			hi_data_o = 1'b1;
			bhe_n_o   = 1'b0;
		end else if (a0_i) begin
			lanes_o   = {wbyte_i, `IOP_BYTE_ZERO};
			lo_data_o = 1'b0;
			hi_data_o = 1'b1;
			bhe_n_o   = 1'b0;
			rbyte_o   = ad_i[15:8];
		end
	end
endmodule

//--- hdl/iop_reqgnt.sv
// pulse request/grant exchange with a host cpu on a shared bus
`timescale 1ns/100ps
`include "iop_bus_regs.svh"
module iop_reqgnt (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic reset_n_i,
	// control
	input  wire logic shared_i,
	input  wire logic need_i,
	output logic      owned_o,
	// open-drain exchange line
	input  wire logic line_i,
	output logic      line_o,
	output logic      line_oe_n_o
);
	import iop_bus_pkg::*;

	iop_rg_state_e state_q;
	iop_rg_state_e state_d;
	logic          owned_q;
	logic          owned_d;
	logic          oe_n_q;
	logic          oe_n_d;

	// request, skip our own echo, wait for grant, own, release when done
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			IOP_RG_IDLE: if (shared_i && need_i) state_d = IOP_RG_REQ;
			IOP_RG_REQ:  state_d = IOP_RG_GAP;
			IOP_RG_GAP:  state_d = IOP_RG_WAIT;
			IOP_RG_WAIT: if (!line_i) state_d = IOP_RG_OWN;
			IOP_RG_OWN:  if (!need_i) state_d = IOP_RG_REL;
			IOP_RG_REL:  state_d = IOP_RG_IDLE;
		endcase
		owned_d = !shared_i || (state_d == IOP_RG_OWN);
		oe_n_d  = (state_d == IOP_RG_REQ || state_d == IOP_RG_REL) ? `IOP_DRIVE_N
		                                                           : `IOP_FLOAT_N;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= IOP_RG_IDLE;
			owned_q <= 1'b0;
			oe_n_q  <= `IOP_FLOAT_N;
		end else begin
			state_q <= state_d;
			owned_q <= owned_d;
			oe_n_q  <= oe_n_d;
		end
	end

	assign owned_o     = owned_q;
	assign line_o      = 1'b0; // the line is only ever pulled low
	assign line_oe_n_o = oe_n_q;
endmodule

//--- hdl/iop_bus_if.sv
// bus interface of a two-channel io processor: four-state multiplexed cycles
// Notes on behaviour
// - memory addresses are 20 bits, io addresses 16 bits, in every mode
// - only the bus owner drives address/data and status; the other floats
// - shared bus: request, await grant, release when done; cpu never requests
// - load limit throttles task program cycles only, never dma transfers
// - io and memory commands both go out on the one multiplexed bus
// - a cycle runs only on demand; otherwise the bus idles
// - each cycle has four states with address and data multiplexed
// - first state drives the address and strobes the address latch
// - second state floats lines for reads, drives data for writes
// - third state holds write data or samples read data; fourth ends it
// - on the 8-bit bus the upper lines keep the address all cycle
// - physical bus width is loaded from cfg_bus16_i whenever cfg_load_i is set while idle
// - logical width of each transfer comes from the width select
// - 8-bit bus: data on low lanes, high byte enable unused
// - 16-bit bus: even byte low lanes, odd byte high lanes, even word all
// - odd word is two byte cycles: low byte high lanes, then high byte low
// - status lines encode fetch, read, write for io and memory, or passive
// - status goes passive before the fourth state, active again if more follows
// - while ready is low, wait states sit between third and fourth states
`timescale 1ns/100ps
`include "iop_bus_regs.svh"
module iop_bus_if (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	// configuration
	input  wire logic        cfg_load_i,
	input  wire logic        cfg_bus16_i,
	input  wire logic        local_mode_i,
	input  wire logic [1:0]  bll_en_i,
	// cycle request from the channels
	input  wire logic        req_valid_i,
	output logic             req_ready_o,
	input  wire logic        req_mem_i,
	input  wire logic        req_write_i,
	input  wire logic        req_fetch_i,
	input  wire logic        req_dma_i,
	input  wire logic        req_chan_i,
	input  wire logic        width_select_instr_i,
	input  wire logic [19:0] req_addr_i,
	input  wire logic [15:0] req_wdata_i,
	// answer
	output logic             rsp_valid_o,
	output logic             rsp_err_o,
	output logic      [15:0] rsp_rdata_o,
	// multiplexed bus pins
	input  wire logic [15:0] muxed_addr_data_lines_i,
	output logic      [15:0] muxed_addr_data_lines_o,
	output logic             ad_lo_oe_n_o,
	output logic             ad_hi_oe_n_o,
	output logic      [3:0]  addr_hi_o,
	output logic             addr_hi_oe_n_o,
	output logic             ale_o,
	output logic             high_byte_enable_n_o,
	output logic             bhe_oe_n_o,
	output logic      [2:0]  cycle_type_code_n_o,
	output logic             code_oe_n_o,
	input  wire logic        ready_i,
	// request/grant line
	input  wire logic        bus_req_grant_line_i,
	output logic             bus_req_grant_line_o,
	output logic             bus_req_grant_line_oe_n_o,
	// state seen by the core
	output logic             bus_owned_o,
	output logic             bus_busy_o,
	output logic             phys16_o
);
	import iop_bus_pkg::*;

	// status code for a cycle kind; used for the first two states and the early code
	function automatic logic [2:0] cyc_code(input logic mem, input logic wr,
	                                        input logic fetch);
		logic [2:0] c;
		c = `IOP_CODE_PASSIVE;
		if (mem) begin
			c = fetch ? `IOP_CODE_MEM_FETCH : (wr ? `IOP_CODE_MEM_WRITE
			                                      : `IOP_CODE_MEM_READ);
		end else begin
			c = fetch ? `IOP_CODE_IO_FETCH : (wr ? `IOP_CODE_IO_WRITE
			                                     : `IOP_CODE_IO_READ);
		end
		return c;
	endfunction

	iop_bus_state_e state_q;
	iop_bus_state_e state_d;
	logic           phys16_q;
	logic           phys16_d;
	logic [19:0]    addr_q;
	logic [19:0]    addr_d;
	logic [15:0]    wdata_q;
	logic [15:0]    wdata_d;
	logic [15:0]    rdata_q;
	logic [15:0]    rdata_d;
	logic           mem_q;
	logic           mem_d;
	logic           wr_q;
	logic           wr_d;
	logic           fetch_q;
	logic           fetch_d;
	logic           dma_q;
	logic           dma_d;
	logic           chan_q;
	logic           chan_d;
	logic           word_q;
	logic           word_d;
	logic           split_q;
	logic           split_d;
	logic           half2_q;
	logic           half2_d;
	logic           cont_q;
	logic           cont_d;
	logic [3:0]     gap_q;
	logic [3:0]     gap_d;
	logic           rsp_valid_q;
	logic           rsp_valid_d;
	logic           rsp_err_q;
	logic           rsp_err_d;
	logic [15:0]    ad_q;
	logic [15:0]    ad_d;
	logic           lo_oe_n_q;
	logic           lo_oe_n_d;
	logic           hi_oe_n_q;
	logic           hi_oe_n_d;
	logic [3:0]     ahi_q;
	logic [3:0]     ahi_d;
	logic           ahi_oe_n_q;
	logic           ahi_oe_n_d;
	logic           ale_q;
	logic           ale_d;
	logic           bhe_n_q;
	logic           bhe_n_d;
	logic [2:0]     code_q;
	logic [2:0]     code_d;
	logic           owned;
	logic           need;
	logic           samp;
	logic           illegal;
	logic           bll_hit;
	logic           accept;
	logic [7:0]     wbyte;
	logic [15:0]    lanes;
	logic           lo_data;
	logic           hi_data;
	logic           lane_bhe_n;
	logic [7:0]     rbyte;

	// ownership is held while a cycle runs or one is asked for
	assign need = (state_q != IOP_IDLE) || req_valid_i;

	iop_reqgnt u_reqgnt (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.shared_i    (local_mode_i),
		.need_i      (need),
		.owned_o     (owned),
		.line_i      (bus_req_grant_line_i),
		.line_o      (bus_req_grant_line_o),
		.line_oe_n_o (bus_req_grant_line_oe_n_o)
	);

	// lane steering works on the next cycle context so pins come from flops
	assign wbyte = half2_d ? wdata_d[15:8] : wdata_d[7:0];

	iop_lane_steer u_lane (
		.phys16_i  (phys16_d),
		.word_i    (word_d),
		.a0_i      (addr_d[0]),
		.wbyte_i   (wbyte),
		.wword_i   (wdata_d),
		.ad_i      (muxed_addr_data_lines_i),
		.lanes_o   (lanes),
		.lo_data_o (lo_data),
		.hi_data_o (hi_data),
		.bhe_n_o   (lane_bhe_n),
		.rbyte_o   ()
	);

	// read byte lane follows the cycle on the bus now, not the next context,
	// whose address has already stepped at the end of a split first half
	assign rbyte = (phys16_q && addr_q[0]) ? muxed_addr_data_lines_i[15:8]
	                                       : muxed_addr_data_lines_i[7:0];

	// request decode; a new cycle may be taken at idle or as the running read or write leaves its data state
	assign samp    = (state_q == IOP_T3 || state_q == IOP_TW) && ready_i;
	assign illegal = width_select_instr_i && !phys16_q;
	assign bll_hit = !dma_q && !split_q && bll_en_i[chan_q];
	// an illegal request is only taken at idle so its error answer stands alone
	assign req_ready_o = owned && (gap_q == `IOP_GAP_ZERO) &&
	                     ((state_q == IOP_IDLE) ||
	                      (samp && !split_q && !bll_hit && !illegal));
	assign accept = req_valid_i && req_ready_o;

	// sequencer and cycle context
	always_comb begin
		state_d     = state_q;
		phys16_d    = phys16_q;
		addr_d      = addr_q;
		wdata_d     = wdata_q;
		rdata_d     = rdata_q;
		mem_d       = mem_q;
		wr_d        = wr_q;
		fetch_d     = fetch_q;
		dma_d       = dma_q;
		chan_d      = chan_q;
		word_d      = word_q;
		split_d     = split_q;
		half2_d     = half2_q;
		cont_d      = cont_q;
		gap_d       = gap_q;
		rsp_valid_d = 1'b0;
		rsp_err_d   = 1'b0;
		// width only changes outside cycles, when cfg_load_i is set
		if (cfg_load_i && state_q == IOP_IDLE) begin
			phys16_d = cfg_bus16_i;
		end
		if (gap_q != `IOP_GAP_ZERO && state_q == IOP_IDLE) begin
			gap_d = gap_q - `IOP_GAP_STEP;
		end
		unique case (state_q)
			IOP_IDLE: if (accept && !illegal) state_d = IOP_T1;
			IOP_T1:   state_d = IOP_T2;
			IOP_T2:   state_d = IOP_T3;
			IOP_T3:   state_d = ready_i ? IOP_T4 : IOP_TW;
			IOP_TW:   state_d = ready_i ? IOP_T4 : IOP_TW;
			IOP_T4: begin
				state_d = cont_q ? IOP_T1 : IOP_IDLE;
				cont_d  = 1'b0;
			end
		endcase
		// sample read data as the cycle leaves its third or last wait state
		if (samp) begin
			if (!wr_q) begin
				if (word_q) begin
					rdata_d = muxed_addr_data_lines_i;
				end else if (split_q) begin
					rdata_d[7:0] = rbyte;
				end else if (half2_q) begin
					rdata_d[15:8] = rbyte;
				end else begin
					rdata_d = {`IOP_BYTE_ZERO, rbyte};
				end
			end
			if (split_q) begin
				addr_d  = addr_q + `IOP_ADDR_STEP;
				split_d = 1'b0;
				half2_d = 1'b1;
				cont_d  = 1'b1;
			end else begin
				rsp_valid_d = 1'b1;
				half2_d     = 1'b0;
				if (bll_hit) begin
					gap_d = `IOP_BLL_GAP;
				end
			end
		end
		if (accept) begin
			if (illegal) begin
				rsp_valid_d = 1'b1;
				rsp_err_d   = 1'b1;
			end else begin
				cont_d  = (state_q != IOP_IDLE);
				mem_d   = req_mem_i;
				wr_d    = req_write_i;
				fetch_d = req_fetch_i && !req_write_i;
				dma_d   = req_dma_i;
				chan_d  = req_chan_i;
				wdata_d = req_wdata_i;
				// io space keeps only sixteen address bits
				addr_d  = req_mem_i ? req_addr_i
				                    : {`IOP_IO_ADDR_HI, req_addr_i[15:0]};
				word_d  = width_select_instr_i && !req_addr_i[0];
				split_d = width_select_instr_i && req_addr_i[0];
				half2_d = 1'b0;
			end
		end
	end

	// pin values for the state being entered
	always_comb begin
		ad_d       = ad_q;
		lo_oe_n_d  = `IOP_FLOAT_N;
		hi_oe_n_d  = `IOP_FLOAT_N;
		ahi_d      = ahi_q;
		ahi_oe_n_d = `IOP_FLOAT_N;
		ale_d      = 1'b0;
		bhe_n_d    = 1'b1;
		code_d     = `IOP_CODE_PASSIVE;
		unique case (state_d)
			IOP_IDLE: begin
				code_d = `IOP_CODE_PASSIVE;
			end
			IOP_T1: begin
				ad_d       = addr_d[15:0];
				ahi_d      = addr_d[19:16];
				lo_oe_n_d  = `IOP_DRIVE_N;
				hi_oe_n_d  = `IOP_DRIVE_N;
				ahi_oe_n_d = `IOP_DRIVE_N;
				ale_d      = 1'b1;
				bhe_n_d    = lane_bhe_n;
				code_d     = cyc_code(mem_d, wr_d, fetch_d);
			end
			IOP_T2, IOP_T3, IOP_TW: begin
				if (wr_d) begin
					ad_d      = lanes;
					lo_oe_n_d = lo_data ? `IOP_DRIVE_N : `IOP_FLOAT_N;
					hi_oe_n_d = hi_data ? `IOP_DRIVE_N : `IOP_FLOAT_N;
				end
				if (!phys16_d) begin
					ad_d[15:8] = addr_d[15:8];
					hi_oe_n_d  = `IOP_DRIVE_N;
				end
				bhe_n_d = lane_bhe_n;
				// passive early so the decoder ends the command on time
				code_d  = (state_d == IOP_T2) ? cyc_code(mem_d, wr_d, fetch_d)
				                              : `IOP_CODE_PASSIVE;
			end
			IOP_T4: begin
				// write data is off the bus by now; only the narrow-bus address stays
				if (!phys16_d) begin
					ad_d[15:8] = addr_q[15:8];
					hi_oe_n_d  = `IOP_DRIVE_N;
				end
				bhe_n_d = bhe_n_q;
				code_d  = cont_d ? cyc_code(mem_d, wr_d, fetch_d)
				                 : `IOP_CODE_PASSIVE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q     <= IOP_IDLE;
			phys16_q    <= 1'b0;
			addr_q      <= `IOP_ADDR_ZERO;
			wdata_q     <= `IOP_WORD_ZERO;
			rdata_q     <= `IOP_WORD_ZERO;
			mem_q       <= 1'b0;
			wr_q        <= 1'b0;
			fetch_q     <= 1'b0;
			dma_q       <= 1'b0;
			chan_q      <= 1'b0;
			word_q      <= 1'b0;
			split_q     <= 1'b0;
			half2_q     <= 1'b0;
			cont_q      <= 1'b0;
			gap_q       <= `IOP_GAP_ZERO;
			rsp_valid_q <= 1'b0;
			rsp_err_q   <= 1'b0;
			ad_q        <= `IOP_WORD_ZERO;
			lo_oe_n_q   <= `IOP_FLOAT_N;
			hi_oe_n_q   <= `IOP_FLOAT_N;
			ahi_q       <= `IOP_IO_ADDR_HI;
			ahi_oe_n_q  <= `IOP_FLOAT_N;
			ale_q       <= 1'b0;
			bhe_n_q     <= 1'b1;
			code_q      <= `IOP_CODE_PASSIVE;
		end else begin
			state_q     <= state_d;
			phys16_q    <= phys16_d;
			addr_q      <= addr_d;
			wdata_q     <= wdata_d;
			rdata_q     <= rdata_d;
			mem_q       <= mem_d;
			wr_q        <= wr_d;
			fetch_q     <= fetch_d;
			dma_q       <= dma_d;
			chan_q      <= chan_d;
			word_q      <= word_d;
			split_q     <= split_d;
			half2_q     <= half2_d;
			cont_q      <= cont_d;
			gap_q       <= gap_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_err_q   <= rsp_err_d;
			ad_q        <= ad_d;
			lo_oe_n_q   <= lo_oe_n_d;
			hi_oe_n_q   <= hi_oe_n_d;
			ahi_q       <= ahi_d;
			ahi_oe_n_q  <= ahi_oe_n_d;
			ale_q       <= ale_d;
			bhe_n_q     <= bhe_n_d;
			code_q      <= code_d;
		end
	end

	// outputs; a non-owner floats everything it could share
	assign muxed_addr_data_lines_o = ad_q;
	assign ad_lo_oe_n_o            = lo_oe_n_q | !owned;
	assign ad_hi_oe_n_o            = hi_oe_n_q | !owned;
	assign addr_hi_o               = ahi_q;
	assign addr_hi_oe_n_o          = ahi_oe_n_q | !owned;
	assign ale_o                   = ale_q;
	assign high_byte_enable_n_o    = bhe_n_q;
	assign bhe_oe_n_o              = !owned;
	assign cycle_type_code_n_o     = code_q;
	assign code_oe_n_o             = !owned;
	assign rsp_valid_o             = rsp_valid_q;
	assign rsp_err_o               = rsp_err_q;
	assign rsp_rdata_o             = rdata_q;
	assign bus_owned_o             = owned;
	assign bus_busy_o              = (state_q != IOP_IDLE);
	assign phys16_o                = phys16_q;
endmodule

//--- dv/iop_bus_if_checker.sv
// concurrent checks on the pins of the io processor bus interface
`timescale 1ns/100ps
module iop_bus_if_checker (
	// clock and reset
	input wire logic        core_clk_i,
	input wire logic        reset_n_i,
	// watched pins
	input wire logic        ready_i,
	input wire logic        ale_o,
	input wire logic        rsp_valid_o,
	input wire logic        rsp_err_o,
	input wire logic        phys16_o,
	input wire logic        bus_owned_o,
	input wire logic        ad_lo_oe_n_o,
	input wire logic        ad_hi_oe_n_o,
	input wire logic        addr_hi_oe_n_o,
	input wire logic        code_oe_n_o,
	input wire logic        high_byte_enable_n_o,
	input wire logic [2:0]  cycle_type_code_n_o,
	input wire logic [15:0] muxed_addr_data_lines_o
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	AST_ALE_GAP: assert property (ale_o |=> !ale_o [*3])
		else $error("address strobe again inside one bus cycle");
	AST_ADDR_OUT: assert property (ale_o |-> !addr_hi_oe_n_o && !ad_lo_oe_n_o && !ad_hi_oe_n_o)
		else $error("address not driven in first state");
	AST_RD_FLOAT: assert property (ale_o && cycle_type_code_n_o[1:0] != 2'b10 |=> ad_lo_oe_n_o [*2])
		else $error("low lanes driven during read");
	AST_WR_DRIVE: assert property (ale_o && cycle_type_code_n_o[1:0] == 2'b10
		|=> !(ad_lo_oe_n_o && ad_hi_oe_n_o) ##1 $stable(muxed_addr_data_lines_o))
		else $error("write data not driven and held");
	AST_CODE_OK: assert property (ale_o |-> cycle_type_code_n_o != 3'h3 && cycle_type_code_n_o != 3'h7)
		else $error("bus cycle without a cycle code");
	AST_CODE_PASSIVE: assert property (ale_o |=> $stable(cycle_type_code_n_o) ##1 cycle_type_code_n_o == 3'h7)
		else $error("cycle code not passive in third state");
	AST_WAIT: assert property (ale_o ##2 !ready_i |=> !rsp_valid_o && !ale_o)
		else $error("cycle ended while ready low");
	AST_BUS8_ADDR: assert property (ale_o && !phys16_o
		|=> (!ad_hi_oe_n_o && $stable(muxed_addr_data_lines_o[15:8])) [*3])
		else $error("upper address lost on narrow bus");
	AST_BHE8: assert property (ale_o && !phys16_o |-> high_byte_enable_n_o)
		else $error("high byte enable active on narrow bus");
	AST_FLOAT: assert property (!bus_owned_o |-> code_oe_n_o && ad_lo_oe_n_o && ad_hi_oe_n_o)
		else $error("bus driven without ownership");
	AST_ERR: assert property (rsp_err_o |-> rsp_valid_o && !phys16_o)
		else $error("error answer outside narrow word case");
endmodule

bind iop_bus_if iop_bus_if_checker u_iop_bus_if_checker (
	.core_clk_i, .reset_n_i, .ready_i, .ale_o, .rsp_valid_o, .rsp_err_o, .phys16_o,
	.bus_owned_o, .ad_lo_oe_n_o, .ad_hi_oe_n_o, .addr_hi_oe_n_o, .code_oe_n_o,
	.high_byte_enable_n_o, .cycle_type_code_n_o, .muxed_addr_data_lines_o
);

//--- dv/iop_far_model.sv
// behavioural host cpu and bus slave facing the io processor pins
`timescale 1ns/100ps
module iop_far_model (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	// bus side
	input  wire logic [2:0]  waits_i,
	input  wire logic        bus16_i,
	input  wire logic        ale_i,
	input  wire logic [2:0]  code_n_i,
	input  wire logic [15:0] ad_i,
	input  wire logic        rg_oe_n_i,
	output logic      [15:0] ad_o,
	output logic             ready_o,
	output logic             grant_n_o,
	output logic      [15:0] wseen_o
);
	logic [15:0] adr_q;
	logic [15:0] junk_q;
	logic        rd_q;
	logic        act_q;
	logic [2:0]  wl_q;
	logic [1:0]  hs_q;
	logic        gnt_q;
	logic        pas;

	// byte at address a reads as a xor 5a; outside read data the lanes toggle
	assign pas = code_n_i == 3'h7;
	assign ready_o = wl_q == 3'h0;
	assign grant_n_o = !gnt_q;
	assign ad_o = !(rd_q && pas) ? junk_q : {{adr_q[7:1], 1'b1} ^ 8'h5a,
		(bus16_i ? {adr_q[7:1], 1'b0} : adr_q[7:0]) ^ 8'h5a};

	// slave cycle tracking and the host grant exchange
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{adr_q, rd_q, act_q, wl_q, hs_q, gnt_q, wseen_o} <= '0;
			junk_q <= 16'ha5c3;
		end else begin
			junk_q <= ~junk_q;
			gnt_q <= 1'b0;
			if (ale_i) begin
				adr_q <= ad_i;
				act_q <= 1'b1;
				rd_q <= code_n_i[1:0] != 2'b10;
				wl_q <= waits_i;
			end else if (act_q && pas) begin
				if (ready_o) begin
					act_q <= 1'b0;
					rd_q <= 1'b0;
					wseen_o <= rd_q ? wseen_o : ad_i;
				end else
					wl_q <= wl_q - 3'h1;
			end
			// host only grants after a request pulse, then waits for the release
			case (hs_q)
				2'h0: hs_q <= rg_oe_n_i ? 2'h0 : 2'h1;
				2'h1: hs_q <= 2'h2;
				2'h2: begin
					hs_q <= 2'h3;
					gnt_q <= 1'b1;
				end
				default: hs_q <= rg_oe_n_i ? 2'h3 : 2'h0;
			endcase
		end
	end
endmodule

//--- dv/iop_bus_if_tb_top.sv
// self-checking bench for the io processor bus interface
`timescale 1ns/100ps
module iop_bus_if_tb_top;
	// design inputs, all valued at time zero
	logic        core_clk_i = 1'b0, reset_n_i = 1'b0, cfg_load_i = 1'b0, cfg_bus16_i = 1'b0;
	logic        local_mode_i = 1'b0, req_valid_i = 1'b0, req_mem_i = 1'b0, req_write_i = 1'b0;
	logic        req_fetch_i = 1'b0, req_dma_i = 1'b0, req_chan_i = 1'b0;
	logic        width_select_instr_i = 1'b0;
	logic [1:0]  bll_en_i = 2'h0;
	logic [19:0] req_addr_i = 20'h00000;
	logic [15:0] req_wdata_i = 16'h0000;
	logic [2:0]  waits = 3'h0;
	// design outputs and bus levels
	logic        req_ready_o, rsp_valid_o, rsp_err_o, ad_lo_oe_n_o, ad_hi_oe_n_o, ale_o, ready_i;
	logic        bus_req_grant_line_i, bus_req_grant_line_oe_n_o, bus_owned_o, phys16_o, grant_n;
	logic [2:0]  cycle_type_code_n_o;
	logic [15:0] rsp_rdata_o, muxed_addr_data_lines_i, muxed_addr_data_lines_o, far_ad, far_w;
	// results of the last transfer
	logic [15:0] rd;
	logic        er;
	logic [2:0]  cd;
	int          lat, wt, error_cnt = 0, cmp_count = 0;

	always #4 core_clk_i = ~core_clk_i;

	// each lane carries whoever enables it; the exchange line is pulled up
	assign muxed_addr_data_lines_i[7:0] = ad_lo_oe_n_o ? far_ad[7:0] : muxed_addr_data_lines_o[7:0];
	assign muxed_addr_data_lines_i[15:8] = ad_hi_oe_n_o ? far_ad[15:8] : muxed_addr_data_lines_o[15:8];
	assign bus_req_grant_line_i = bus_req_grant_line_oe_n_o & grant_n;

	iop_bus_if u_iop_bus_if (
		.core_clk_i, .reset_n_i, .cfg_load_i, .cfg_bus16_i, .local_mode_i, .bll_en_i,
		.req_valid_i, .req_ready_o, .req_mem_i, .req_write_i, .req_fetch_i, .req_dma_i,
		.req_chan_i, .width_select_instr_i, .req_addr_i, .req_wdata_i, .rsp_valid_o,
		.rsp_err_o, .rsp_rdata_o, .muxed_addr_data_lines_i, .muxed_addr_data_lines_o,
		.ad_lo_oe_n_o, .ad_hi_oe_n_o, .addr_hi_o(), .addr_hi_oe_n_o(), .ale_o,
		.high_byte_enable_n_o(), .bhe_oe_n_o(), .cycle_type_code_n_o, .code_oe_n_o(),
		.ready_i, .bus_req_grant_line_i, .bus_req_grant_line_o(), .bus_req_grant_line_oe_n_o,
		.bus_owned_o, .bus_busy_o(), .phys16_o
	);

	iop_far_model u_iop_far_model (
		.core_clk_i, .reset_n_i, .waits_i(waits), .bus16_i(phys16_o), .ale_i(ale_o),
		.code_n_i(cycle_type_code_n_o), .ad_i(muxed_addr_data_lines_i),
		.rg_oe_n_i(bus_req_grant_line_oe_n_o), .ad_o(far_ad), .ready_o(ready_i),
		.grant_n_o(grant_n), .wseen_o(far_w)
	);

	function automatic logic [7:0] mb(input logic [19:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// k = {mem, write, fetch, dma, chan, word}; wt counts refused cycles, lat cycles to answer
	task automatic xfer(input logic [5:0] k, input logic [19:0] a, input logic [15:0] wd);
		@(negedge core_clk_i);
		{req_mem_i, req_write_i, req_fetch_i, req_dma_i, req_chan_i, width_select_instr_i} = k;
		req_addr_i = a;
		req_wdata_i = wd;
		req_valid_i = 1'b1;
		wt = 0;
		lat = 0;
		cd = 3'h7;
		#1;
		while (req_ready_o !== 1'b1 && wt < 300) begin
			@(negedge core_clk_i);
			#1;
			wt++;
		end
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		while (rsp_valid_o !== 1'b1 && lat < 300) begin
			if (ale_o === 1'b1 && cd === 3'h7) cd = cycle_type_code_n_o;
			@(negedge core_clk_i);
			lat++;
		end
		rd = rsp_rdata_o;
		er = rsp_err_o;
	endtask

	task automatic t_reset();
		chk(phys16_o, 1'b0);
		chk(cycle_type_code_n_o, 3'h7);
	endtask

	// narrow bus: word refused at once, bytes on the low lanes
	task automatic t_bus8();
		xfer(6'b100001, 20'h00040, 16'h0000);
		chk(er, 1'b1);
		chk(20'(lat), 20'h0);
		xfer(6'b100000, 20'h00043, 16'h0000);
		chk(rd, {8'h00, mb(20'h00043)});
		xfer(6'b010000, 20'h01234, 16'h00c7);
		chk(far_w[7:0], 8'hc7);
	endtask

	task automatic t_cfg();
		@(negedge core_clk_i);
		cfg_bus16_i = 1'b1;
		cfg_load_i = 1'b1;
		@(negedge core_clk_i);
		cfg_load_i = 1'b0;
		chk(phys16_o, 1'b1);
	endtask

	// every io and memory cycle kind as an even word
	task automatic t_codes();
		logic [19:0] a;
		for (int i = 0; i < 8; i++) begin
			a = 20'h0a2c0 + 20'(i * 2);
			xfer({i[2:0], 3'b001}, a, 16'h3c00 + 16'(i));
			chk(cd, i[1] ? {i[2], 2'b10} : {i[2], 1'b0, !i[0]});
			chk(20'(lat), 20'h3);
			if (i[1]) chk(far_w, 16'h3c00 + 16'(i));
			else chk(rd, {mb(a + 20'h1), mb(a)});
		end
	endtask

	// odd words split in two byte cycles, odd byte on the high lanes
	task automatic t_odd();
		xfer(6'b100001, 20'h00135, 16'h0000);
		chk(rd, {mb(20'h00136), mb(20'h00135)});
		xfer(6'b110001, 20'h00137, 16'hbe71);
		chk(far_w[7:0], 8'hbe);
		xfer(6'b100000, 20'h00139, 16'h0000);
		chk(rd, {8'h00, mb(20'h00139)});
	endtask

	task automatic t_wait();
		waits = 3'h2;
		xfer(6'b100001, 20'h00a08, 16'h0000);
		waits = 3'h0;
		chk(20'(lat), 20'h5);
		chk(rd, {mb(20'h00a09), mb(20'h00a08)});
	endtask

	// load limit on channel 0: dma passes at once; channel 1 waits out the gap left by channel 0, then passes at once
	task automatic t_bll();
		bll_en_i = 2'h1;
		xfer(6'b100101, 20'h00200, 16'h0000);
		xfer(6'b100001, 20'h00202, 16'h0000);
		chk(20'(wt), 20'h0);
		xfer(6'b100011, 20'h00204, 16'h0000);
		chk(20'(wt > 4), 20'h1);
		xfer(6'b100011, 20'h00206, 16'h0000);
		chk(20'(wt), 20'h0);
		bll_en_i = 2'h0;
	endtask

	// shared bus after a second reset: no ownership until granted, released when idle
	task automatic t_local();
		@(negedge core_clk_i);
		local_mode_i = 1'b1;
		reset_n_i = 1'b0;
		repeat (6) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk(bus_owned_o, 1'b0);
		xfer(6'b100000, 20'h00052, 16'h0000);
		chk(rd, {8'h00, mb(20'h00052)});
		chk(20'(wt > 2), 20'h1);
		repeat (4) @(negedge core_clk_i);
		chk(bus_owned_o, 1'b0);
	endtask

	task automatic give_verdict();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (6) @(negedge core_clk_i);
		reset_n_i = 1'b1;
		t_reset();
		t_bus8();
		t_cfg();
		t_codes();
		t_odd();
		t_wait();
		t_bll();
		t_local();
		give_verdict();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end
endmodule
